//--- design/rsnde_pkg.sv
// Constants shared by the reset, NMI and debug entry logic
package rsnde_pkg;
   // Clock and timing figures
   localparam int CLK_PERIOD_NS   = 50;
   localparam int RST_MIN_NS      = 100;
   localparam int RST_MIN_EXTRA   = 2;
   localparam int RST_MIN_CYC     = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
                                    + RST_MIN_EXTRA;
   localparam int SYNC_STAGES     = 2;
   // Reset values of state bits
   localparam logic RST_PIN_IDLE  = 1'h1;
   localparam logic NMI_PIN_IDLE  = 1'h1;
   localparam logic SYS_RST_INIT  = 1'h1;
   localparam logic PD_INIT       = 1'h0;
   localparam logic DBG_EN_INIT   = 1'h0;
   localparam logic DBG_ARM_INIT  = 1'h0;
   localparam logic PULSE_INIT    = 1'h0;
endpackage

//--- design/rsnde_sync_if.sv
// Interface carrying the reset pin into and out of its synchroniser
`timescale 1ns/1ps
interface rsnde_sync_if;
   logic raw;
   logic synced;
   modport sync (input raw, output synced);
   modport user (output raw, input synced);
endinterface

//--- design/rsnde_sync.sv
// Multi-stage synchroniser for the external reset pin
`timescale 1ns/1ps
module rsnde_sync
   import rsnde_pkg::*;
#(
   parameter int STAGES = rsnde_pkg::SYNC_STAGES
) (
   input  wire logic    clk,
   input  wire logic    rst_n,
   rsnde_sync_if.sync   port
);
   typedef struct packed {
      logic [STAGES-1:0] chain;
   } rsnde_sync_s;

   rsnde_sync_s s_q;
   rsnde_sync_s s_d;

   // Fewer than two stages would let metastability reach the logic
   if (STAGES < 2) begin : g_chk
      $error("rsnde_sync needs at least two stages");
   end

   // Shift the pin in; only the last stage is read outside the chain
   always_comb begin
      s_d = s_q;
      s_d.chain = {s_q.chain[STAGES-2:0], port.raw};
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q.chain <= {STAGES{RST_PIN_IDLE}};
      end else begin
         s_q <= s_d;
      end
   end

   assign port.synced = s_q.chain[STAGES-1];
endmodule

//--- design/rsnde_top.sv
// Reset input, non-maskable interrupt and debug entry control
`timescale 1ns/1ps
// Operation
// - Low reset pin resets the device
// - NMI falling edge raises the trap request
// - Power-down with NMI low enters power-down
// - Power-down with NMI high keeps normal run
// - Test-reset high at reset release enables debug
// - One test-reset low pulse resets debug system
module rsnde_top
   import rsnde_pkg::*;
#(
   parameter int SYNC_N = rsnde_pkg::SYNC_STAGES
) (
   input  wire logic SYS_CLK,
   input  wire logic RESETN,
   input  wire logic EXTERNAL_RESET_PIN_N,
   input  wire logic NMI_PIN_N,
   input  wire logic TEST_RESET_PIN,
   input  wire logic POWER_DOWN_INSTRUCTION,
   output logic      SYS_RESET,
   output logic      NMI_TRAP,
   output logic      POWER_DOWN,
   output logic      DEBUG_ENABLE,
   output logic      DEBUG_SYS_RESET
);
   import rsnde_pkg::*;

   typedef struct packed {
      logic pin_prev;   // Previous synchronised reset pin
      logic sys_rst;    // Confirmed system reset
      logic nmi_prev;   // Previous NMI pin level
      logic nmi_trap;   // Trap request pulse
      logic pd;         // Power-down mode
      logic dbg_en;     // Debug system activated
      logic dbg_arm;    // Waiting for the test-reset low pulse
      logic dbg_rst;    // Debug system reset pulse
   } rsnde_state_s;

   // Registered state, its next value and the link to the synchroniser
   rsnde_state_s  st_q;
   rsnde_state_s  st_d;
   rsnde_sync_if  sif ();
   logic          pin_s;
   logic          release_ev;

   if (SYNC_N < 2) begin : g_chk
      $error("rsnde_top needs SYNC_N of at least two");
   end

   // The raw pin passes only through the synchroniser
   assign sif.raw = EXTERNAL_RESET_PIN_N;
   assign pin_s   = sif.synced;

   // Two or more flip-flops stand between the board pin and the reset filter
   rsnde_sync #(
      .STAGES (SYNC_N)
   ) u_sync (
      .clk   (SYS_CLK),
      .rst_n (RESETN),
      .port  (sif)
   );

   // Release is the first high sample while reset is confirmed
   assign release_ev = st_q.sys_rst && pin_s;

   // Next-state logic for reset, NMI, power-down and debug entry
   always_comb begin
      st_d = st_q;
      // Previous synchronised sample, kept for the pair test below
      st_d.pin_prev = pin_s;
      // Two low samples in a row filter a single-cycle glitch
      if (!pin_s && !st_q.pin_prev) begin
         st_d.sys_rst = 1'h1;
      end else if (pin_s) begin
         // One high sample ends reset; a lone low sample just holds the level
         st_d.sys_rst = 1'h0;
      end
      // The NMI pin is taken as synchronous, so no extra stage delays the trap
      st_d.nmi_prev = NMI_PIN_N;
      // Trap requests are meaningless while the core is in reset
      st_d.nmi_trap = st_q.nmi_prev && !NMI_PIN_N && !st_q.sys_rst;
      // Power-down is a level that only a confirmed reset clears, so the
      // instruction never needs to stand for more than one cycle
      if (st_q.sys_rst) begin
         st_d.pd = PD_INIT;
      end else if (POWER_DOWN_INSTRUCTION && !NMI_PIN_N) begin
         st_d.pd = 1'h1;
      end else begin
         st_d.pd = st_q.pd;
      end
      // Debug enable is captured once per release; the arm bit lets exactly
      // one later test-reset low pulse reset the debug system
      st_d.dbg_rst = 1'h0;
      if (release_ev) begin
         st_d.dbg_en  = TEST_RESET_PIN;
         st_d.dbg_arm = TEST_RESET_PIN;
      end else if (st_q.dbg_arm && !TEST_RESET_PIN && !st_q.sys_rst) begin
         st_d.dbg_arm = 1'h0;
         st_d.dbg_rst = 1'h1;
      end
   end

   // State register; outputs sit directly on its bits
   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         st_q.pin_prev <= RST_PIN_IDLE;
         st_q.sys_rst  <= SYS_RST_INIT;
         st_q.nmi_prev <= NMI_PIN_IDLE;
         st_q.nmi_trap <= PULSE_INIT;
         st_q.pd       <= PD_INIT;
         st_q.dbg_en   <= DBG_EN_INIT;
         st_q.dbg_arm  <= DBG_ARM_INIT;
         st_q.dbg_rst  <= PULSE_INIT;
      end else begin
         st_q <= st_d;
      end
   end

   assign SYS_RESET       = st_q.sys_rst;
   assign NMI_TRAP        = st_q.nmi_trap;
   assign POWER_DOWN      = st_q.pd;
   assign DEBUG_ENABLE    = st_q.dbg_en;
   assign DEBUG_SYS_RESET = st_q.dbg_rst;

   // Checks on the behaviour above
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RESETN);

   // Reset pin filter and confirmed reset
   a_rst_confirm: assert property ((!pin_s && !st_q.pin_prev) |=> SYS_RESET)
      else $error("reset not confirmed after two low samples");

   a_rst_glitch: assert property ((!SYS_RESET && st_q.pin_prev && !pin_s ##1 pin_s)
         |=> !SYS_RESET)
      else $error("single low sample caused reset");

   a_rst_hold: assert property ((SYS_RESET && !pin_s) |=> SYS_RESET)
      else $error("reset dropped while pin low");

   // One high synchronised sample ends the confirmed reset
   a_rst_release: assert property ((SYS_RESET && pin_s) |=> !SYS_RESET)
      else $error("reset held after pin released");

   // Reset is never raised without a pair of low samples
   a_rst_quiet: assert property ((!SYS_RESET && (pin_s || st_q.pin_prev))
         |=> !SYS_RESET)
      else $error("reset raised without two low samples");

   // Non-maskable trap requests
   a_nmi_trap: assert property ((st_q.nmi_prev && !NMI_PIN_N && !SYS_RESET)
         |=> NMI_TRAP ##1 !NMI_TRAP)
      else $error("NMI edge gave no single trap pulse");

   a_trap_cause: assert property (NMI_TRAP |->
         $past(st_q.nmi_prev) && !$past(NMI_PIN_N))
      else $error("trap without NMI falling edge");

   // A trap request stands for one cycle only
   a_trap_single: assert property (NMI_TRAP |=> !NMI_TRAP)
      else $error("trap request longer than one cycle");

   // Falling edges seen during reset give no trap
   a_trap_quiet: assert property (SYS_RESET |=> !NMI_TRAP)
      else $error("trap request raised during reset");

   // Power-down entry and exit
   a_pd_enter: assert property ((POWER_DOWN_INSTRUCTION && !NMI_PIN_N && !SYS_RESET)
         |=> POWER_DOWN)
      else $error("power-down not entered with NMI low");

   a_pd_block: assert property ((POWER_DOWN_INSTRUCTION && NMI_PIN_N && !POWER_DOWN)
         |=> !POWER_DOWN)
      else $error("power-down entered with NMI high");

   // Power-down is reached only through the instruction with NMI low
   a_pd_cause: assert property ($rose(POWER_DOWN) |->
         $past(POWER_DOWN_INSTRUCTION) && !$past(NMI_PIN_N))
      else $error("power-down entered without instruction and NMI low");

   // Without the instruction the core stays in normal run
   a_pd_idle: assert property ((!POWER_DOWN_INSTRUCTION && !POWER_DOWN)
         |=> !POWER_DOWN)
      else $error("power-down entered without the instruction");

   // Once entered, power-down lasts until a confirmed reset
   a_pd_hold: assert property ((POWER_DOWN && !SYS_RESET) |=> POWER_DOWN)
      else $error("power-down left without reset");

   // A confirmed reset always brings the core out of power-down
   a_pd_clear: assert property (SYS_RESET |=> !POWER_DOWN)
      else $error("power-down kept through reset");

   // Debug entry at reset release
   a_dbg_sample: assert property (release_ev |=> DEBUG_ENABLE == $past(TEST_RESET_PIN))
      else $error("debug enable not sampled at release");

   // Debug enable moves only at a reset release
   a_dbg_hold: assert property (!release_ev |=> $stable(DEBUG_ENABLE))
      else $error("debug enable changed outside a release");

   // The arm bit is set only by a release with test-reset high
   a_dbg_arm: assert property ($rose(st_q.dbg_arm) |-> $past(release_ev))
      else $error("debug arm set outside a release");

   // A release with test-reset low leaves the debug system disarmed
   a_dbg_off: assert property ((release_ev && !TEST_RESET_PIN)
         |=> (!st_q.dbg_arm && !DEBUG_ENABLE))
      else $error("debug armed after release with test-reset low");

   // Debug system reset pulse
   a_dbg_reset: assert property ((st_q.dbg_arm && !TEST_RESET_PIN && !SYS_RESET && !release_ev)
         |=> DEBUG_SYS_RESET ##1 (!DEBUG_SYS_RESET && !st_q.dbg_arm))
      else $error("debug reset pulse missing or repeated");

   // The debug reset pulse stands for one cycle only
   a_dbg_single: assert property (DEBUG_SYS_RESET |=> !DEBUG_SYS_RESET)
      else $error("debug reset pulse longer than one cycle");

   // The pulse follows an armed low sample of the test-reset pin
   a_dbg_cause: assert property (DEBUG_SYS_RESET |->
         $past(st_q.dbg_arm) && !$past(TEST_RESET_PIN))
      else $error("debug reset pulse without armed low sample");
endmodule

//--- verif/rsnde_board.sv
// Board reset circuit and debug probe driving the control pins
`timescale 1ns/1ps
module rsnde_board (
   input  wire logic clk,
   output logic      rst_pin_n,
   output logic      nmi_pin_n,
   output logic      test_pin
);
   // Probe attached from power-up, so debug is requested at the first release
   initial begin
      rst_pin_n = 1'h1;
      nmi_pin_n = 1'h1;
      test_pin  = 1'h1;
   end
   // Set all pins just after an edge and hold them for cyc edges
   task automatic put(input logic r, input logic n, input logic t, input int cyc);
      @(posedge clk);
      #1;
      rst_pin_n = r;
      nmi_pin_n = n;
      test_pin  = t; // Low when not debugging, one low after entry
      repeat (cyc - 1) @(posedge clk);
   endtask
endmodule

//--- verif/testbench.sv
// Self-checking bench for the reset, NMI and debug entry block
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin failures++; \
   $display("wrong value at %0t: got %0h want %0h", $time, a, e); end end
module testbench;
   import rsnde_pkg::*;
   logic       SYS_CLK = 1'h0;
   logic       RESETN = 1'h0;
   logic       pd_instr = 1'h0;
   wire        rst_n, nmi_n, test;
   wire  [4:0] outs;
   logic [4:0] prev = 5'h10;
   logic [4:0] q[$];
   int         failures = 0;
   int         checks_done = 0;
   int         seed = 36914;
   always #25 SYS_CLK = ~SYS_CLK;
   rsnde_board board (.clk(SYS_CLK), .rst_pin_n(rst_n), .nmi_pin_n(nmi_n), .test_pin(test));
   rsnde_top DUT (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .EXTERNAL_RESET_PIN_N(rst_n),
      .NMI_PIN_N(nmi_n), .TEST_RESET_PIN(test), .POWER_DOWN_INSTRUCTION(pd_instr),
      .SYS_RESET(outs[4]), .NMI_TRAP(outs[3]), .POWER_DOWN(outs[2]),
      .DEBUG_ENABLE(outs[1]), .DEBUG_SYS_RESET(outs[0]));
   // Every change of the outputs is one result, matched to the oldest note;
   // a change with no note left compares against an unknown and fails
   always @(negedge SYS_CLK) begin : mon
      logic [4:0] e;
      e = 5'hx;
      if (RESETN && outs !== prev) begin
         if (q.size() > 0)
            e = q.pop_front();
         `CHK(outs, e)
      end
      prev = outs;
   end
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // One-cycle power-down instruction from the core
   task automatic pd_pulse();
      repeat (1 + $unsigned($random(seed)) % 3) @(posedge SYS_CLK);
      #1;
      pd_instr = 1'h1;
      @(posedge SYS_CLK);
      #1;
      pd_instr = 1'h0;
   endtask
   // Hang guard at 3000 cycles, far beyond the fewer than 70 cycles the run needs
   initial begin
      #(3000 * 50);
      failures++;
      give_verdict();
   end
   initial begin
      repeat (16) @(posedge SYS_CLK);
      #1;
      q = {q, 5'h02};
      RESETN = 1'h1;
      // Debug entry, one reset pulse, a second low ignored
      q = {q, 5'h03, 5'h02};
      board.put(1, 1, 0, 3);
      board.put(1, 1, 1, 2);
      board.put(1, 1, 0, 3);
      $display("debug entry test done");
      // Back-to-back NMI edges at two-cycle spacing
      q = {q, 5'h0a, 5'h02, 5'h0a, 5'h02};
      board.put(1, 0, 0, 1);
      board.put(1, 1, 0, 1);
      board.put(1, 0, 0, 3);
      $display("nmi test done");
      // Power-down refused with NMI high, taken with NMI low
      board.put(1, 1, 0, 1);
      pd_pulse();
      q = {q, 5'h0a, 5'h02, 5'h06};
      board.put(1, 0, 0, 2);
      pd_pulse();
      $display("power-down test done");
      // Single low sample filtered; full low resets, NMI during reset ignored
      q = {q, 5'h16, 5'h12, 5'h00};
      board.put(0, 1, 0, 1);
      board.put(1, 1, 0, 4);
      board.put(0, 1, 0, 4);
      board.put(0, 0, 0, RST_MIN_CYC + $unsigned($random(seed)) % 4);
      board.put(1, 1, 0, 8);
      `CHK(q.size(), 0)
      $display("reset pin test done");
      give_verdict();
   end
endmodule
